/* adc_strobe_defines.svh */
// Timing counts, widths and sizes for the converter output timing block.
`ifndef ADC_STROBE_DEFINES_SVH
`define ADC_STROBE_DEFINES_SVH

// ==========================================================================
// Data path
`define WORD_W 10
`define PIPE_LATENCY 4
`define SAMPLE_LINE_DEPTH (`PIPE_LATENCY + 1)
`define WARM_W 3
`define WARM_ZERO 3'h0
`define WARM_STEP 3'h1
`define WARM_FULL 3'h5

// ==========================================================================
// Crossings and core status
`define SYNC_STAGES 3
`define XING_W 2
`define XING_RUN 0
`define XING_LOCK 1
`define RESTART_CNT_W 8
`define RESTART_CNT_ZERO 8'h00
`define RESTART_CNT_STEP 8'h01

// ==========================================================================
// Times
`define CORE_CLK_MHZ 25
`define CORE_CLK_PERIOD_NS 40
`define MIN_STROBE_RESET_PULSE_NS 1
`define MIN_CONVERSION_RATE_MSPS 150

`endif

/* adc_strobe_pkg.sv */
// Types shared by the converter output timing block.
`include "adc_strobe_defines.svh"

package adc_strobe_pkg;

  typedef logic [`WORD_W-1:0] conv_word_t;

  typedef logic [`XING_W-1:0] xing_bits_t;

  typedef enum logic [3:0] {
    FRM_SEEK_FIRST = 4'h1,
    FRM_SEEK_SECOND = 4'h2,
    FRM_SEEK_THIRD = 4'h4,
    FRM_LOCKED = 4'h8
  } frame_state_t;

endpackage : adc_strobe_pkg

/* adc_strobe_timing.sv */
// Output data timing and data-ready strobe control of a pipelined converter.
`include "adc_strobe_defines.svh"

module adc_strobe_timing (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Conversion clock and strobe reset
  input wire logic conversion_clock_i,
  input wire logic strobe_reset_n_i,
  // Sample stream
  input wire adc_strobe_pkg::conv_word_t sample_word_i,
  output adc_strobe_pkg::conv_word_t converted_word_o,
  output logic output_valid_strobe_o,
  // Core-side status
  output logic strobe_running_o,
  output logic first_word_pulse_o,
  output logic [`RESTART_CNT_W-1:0] restart_count_o
);
  import adc_strobe_pkg::*;

  // ==========================================================================
  // Declarations
  logic armed_r;
  logic strobe_r;
  logic strobe_nxt;
  logic rise_now;
  frame_state_t frame_state_r;
  frame_state_t frame_state_nxt;
  logic frame_locked_r;
  xing_bits_t xing_src;
  xing_bits_t sync1_r;
  xing_bits_t sync2_r;
  xing_bits_t sync3_r;
  xing_bits_t filt_r;
  xing_bits_t filt_nxt;
  logic running_r;
  logic first_pulse_r;
  logic [`RESTART_CNT_W-1:0] restart_cnt_r;
  logic [`RESTART_CNT_W-1:0] restart_cnt_nxt;
  logic [`WARM_W-1:0] conv_warm_r;
  conv_word_t first_sample_r;
  logic strobe_at_rise_r;
  logic strobe_live_r;

  conv_word_if word_bus (
    .clk(conversion_clock_i)
  );

  // ==========================================================================
  // Sample capture and pipeline latency
  assign word_bus.sample_word = sample_word_i;

  sample_delay_line #(
    .DEPTH(`SAMPLE_LINE_DEPTH)
  ) u_delay_line (
    .port(word_bus.line)
  );

  assign converted_word_o = word_bus.aligned_word;

  // ==========================================================================
  // Restart arming on the rising conversion edge.
  // The strobe reset acts without a clock, so the arm flag clears at once. A
  // release is only honoured at the next rising edge, which places the first
  // strobe rise on the falling edge after it: half a period on when the clock
  // was low at release, a full period on when it was high.
  always_ff @(posedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Data-ready strobe on the falling conversion edge.
  // With the reset input tied high the arm flag stays set and the strobe runs.
  assign strobe_nxt = armed_r ? ~strobe_r : 1'b0;

  always_ff @(negedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= strobe_nxt;
    end
  end

  assign output_valid_strobe_o = strobe_r;

  // ==========================================================================
  // Framing of the first acquired sample after a restart.
  // Strobe rises are counted; the third one frames the first word.
  assign rise_now = armed_r & ~strobe_r;

  always_comb begin
    frame_state_nxt = frame_state_r;
    case (frame_state_r)
      FRM_SEEK_FIRST: begin
        if (rise_now) begin
          frame_state_nxt = FRM_SEEK_SECOND;
        end
      end
      FRM_SEEK_SECOND: begin
        if (rise_now) begin
          frame_state_nxt = FRM_SEEK_THIRD;
        end
      end
      FRM_SEEK_THIRD: begin
        if (rise_now) begin
          frame_state_nxt = FRM_LOCKED;
        end
      end
      FRM_LOCKED: begin
        frame_state_nxt = FRM_LOCKED;
      end
      default: begin
        frame_state_nxt = FRM_SEEK_FIRST;
      end
    endcase
  end

  always_ff @(negedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      frame_state_r <= FRM_SEEK_FIRST;
    end else begin
      frame_state_r <= frame_state_nxt;
    end
  end

  // A registered copy of the lock level feeds the crossing, so no decode
  // glitch can reach the synchroniser.
  always_ff @(negedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      frame_locked_r <= 1'b0;
    end else begin
      frame_locked_r <= (frame_state_nxt == FRM_LOCKED);
    end
  end

  // ==========================================================================
  // Crossing of the run and lock levels into the core domain.
  // A level change counts once the second and third stages agree.
  assign xing_src[`XING_RUN] = armed_r;
  assign xing_src[`XING_LOCK] = frame_locked_r;

  always_ff @(posedge core_clk_i) begin
    sync1_r <= xing_src;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  assign filt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // The lock level is tracked through the core reset, so that a lock
      // already held is not counted again as a new restart.
      filt_r[`XING_RUN] <= 1'b0;
      filt_r[`XING_LOCK] <= filt_nxt[`XING_LOCK];
    end else begin
      filt_r <= filt_nxt;
    end
  end

  // ==========================================================================
  // Core-side status outputs
  assign restart_cnt_nxt = restart_cnt_r + `RESTART_CNT_STEP;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      running_r <= 1'b0;
      first_pulse_r <= 1'b0;
    end else begin
      running_r <= filt_r[`XING_RUN];
      first_pulse_r <= filt_nxt[`XING_LOCK] & ~filt_r[`XING_LOCK];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      restart_cnt_r <= `RESTART_CNT_ZERO;
    end else if (filt_nxt[`XING_LOCK] & ~filt_r[`XING_LOCK]) begin
      restart_cnt_r <= restart_cnt_nxt;
    end
  end

  assign strobe_running_o = running_r;
  assign first_word_pulse_o = first_pulse_r;
  assign restart_count_o = restart_cnt_r;

  // ==========================================================================
  // Checking helpers.
  // The warm count tells when the delay line holds samples taken since the
  // last strobe reset; the first sample is the one taken at the arming edge.
  always_ff @(posedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      conv_warm_r <= `WARM_ZERO;
    end else if (conv_warm_r != `WARM_FULL) begin
      conv_warm_r <= conv_warm_r + `WARM_STEP;
    end
  end

  always_ff @(posedge conversion_clock_i) begin
    if (!armed_r) begin
      first_sample_r <= sample_word_i;
    end
  end

  // The strobe level seen at each rising edge, and a flag that is set at a
  // falling edge only while armed, cleared at once by any strobe reset.
  always_ff @(posedge conversion_clock_i) begin
    strobe_at_rise_r <= strobe_r;
  end

  always_ff @(negedge conversion_clock_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      strobe_live_r <= 1'b0;
    end else begin
      strobe_live_r <= armed_r;
    end
  end

  // ==========================================================================
  // Assertions
  sequence strobe_reset_released;
    !armed_r ##1 armed_r;
  endsequence

  sequence third_rise_due;
    (frame_state_r == FRM_SEEK_THIRD) && armed_r && !strobe_r;
  endsequence

  sequence first_word_framed;
    (converted_word_o == first_sample_r) ##1 frame_locked_r;
  endsequence

  a_sample_per_period: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    (conv_warm_r == `WARM_FULL) |-> converted_word_o == $past(sample_word_i, 5)
  ) else $error("Output word does not follow one sample per rising edge.");

  a_pipe_latency_four: assert property (
    @(posedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    (conv_warm_r == `WARM_FULL) |-> converted_word_o == $past(sample_word_i, 5)
  ) else $error("Output word is not the sample taken four periods earlier.");

  a_strobe_half_rate: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    strobe_live_r |-> (strobe_r != $past(strobe_r))
  ) else $error("Strobe did not toggle on a falling edge while running.");

  a_strobe_no_rise_edge: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    armed_r |-> (strobe_r == strobe_at_rise_r)
  ) else $error("Strobe changed between a rising edge and the next falling edge.");

  a_reset_forces_low: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !strobe_reset_n_i |-> !output_valid_strobe_o
  ) else $error("Strobe not low while strobe reset is asserted.");

  a_reset_holds_low: assert property (
    @(negedge conversion_clock_i)
    (!strobe_reset_n_i ##1 !strobe_reset_n_i) |-> !strobe_r && !armed_r
  ) else $error("Strobe or arm flag moved while strobe reset was held.");

  a_restart_first_rise: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    strobe_reset_released |=> strobe_r ##1 !strobe_r ##1 strobe_r
  ) else $error("Strobe did not restart on the first falling edge after arming.");

  a_restart_high_skip: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    !armed_r |=> !strobe_r
  ) else $error("Strobe rose before a rising edge had armed the restart.");

  a_third_rise_frame: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    third_rise_due |-> first_word_framed
  ) else $error("Third strobe rise does not frame the first acquired sample.");

  a_lock_after_third: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    third_rise_due |=> (frame_state_r == FRM_LOCKED)
  ) else $error("Framing did not lock at the third strobe rise.");

  a_strobe_low_unarmed: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    !armed_r |-> !strobe_r
  ) else $error("Strobe high while the restart was not armed.");

  a_frame_starts_first: assert property (
    @(negedge conversion_clock_i) disable iff (!strobe_reset_n_i)
    strobe_reset_released |-> (frame_state_r == FRM_SEEK_FIRST)
  ) else $error("Framing did not start from the first rise after a restart.");

  // ==========================================================================
  // Core-domain assertions.
  // The status outputs are checked against the core reset and against each
  // other, since the crossing makes their exact cycle depend on phase.
  a_status_reset_clear: assert property (
    @(posedge core_clk_i)
    sys_rst_i |=> !running_r && !first_pulse_r && (restart_cnt_r == `RESTART_CNT_ZERO)
  ) else $error("Core status not cleared by the core reset.");

  a_pulse_one_cycle: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    first_pulse_r |=> !first_pulse_r
  ) else $error("First word pulse lasted more than one core cycle.");

  a_count_on_pulse: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    first_pulse_r |-> (restart_cnt_r == $past(restart_cnt_r) + `RESTART_CNT_STEP)
  ) else $error("Restart count did not step with the first word pulse.");

  a_count_holds: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!first_pulse_r && !$past(sys_rst_i)) |-> $stable(restart_cnt_r)
  ) else $error("Restart count moved without a first word pulse.");

  a_first_needs_run: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    first_pulse_r |-> running_r
  ) else $error("First word pulse while the strobe was not running.");

endmodule : adc_strobe_timing

/* conv_word_if.sv */
// Carrier between the top module and the sample delay line.
interface conv_word_if (
  input wire logic clk
);
  import adc_strobe_pkg::*;

  conv_word_t sample_word;
  conv_word_t aligned_word;

  modport line (input clk, input sample_word, output aligned_word);
  modport user (input aligned_word, output sample_word);

endinterface : conv_word_if

/* sample_delay_line.sv */
// Fixed-latency delay line clocked on the rising conversion clock edge.
`include "adc_strobe_defines.svh"

module sample_delay_line #(
  parameter int DEPTH = `SAMPLE_LINE_DEPTH
) (
  // Conversion-clock data carrier
  conv_word_if.line port
);
  import adc_strobe_pkg::*;

  conv_word_t stage_r [DEPTH];

  // ==========================================================================
  // Capture stage and latency stages
  always_ff @(posedge port.clk) begin
    stage_r[0] <= port.sample_word;
    for (int i = 1; i < DEPTH; i++) begin
      stage_r[i] <= stage_r[i-1];
    end
  end

  assign port.aligned_word = stage_r[DEPTH-1];

endmodule : sample_delay_line

/* strobe_capture_model.sv */
// Behavioural model of the downstream capture logic fed by the converter.
module strobe_capture_model (
  // Strobe, strobe reset and data from the converter
  input wire logic strobe_i,
  input wire logic strobe_reset_n_i,
  input wire adc_strobe_pkg::conv_word_t word_i,
  // Captured stream
  output adc_strobe_pkg::conv_word_t capt_word_o,
  output logic first_seen_o = 1'b0,
  output adc_strobe_pkg::conv_word_t first_word_o
);
  import adc_strobe_pkg::*;

  int rises = 0;

  // Each strobe transition marks one new word, so both edges capture.
  always @(strobe_i) begin
    capt_word_o = word_i;
  end

  // The third strobe rise after a restart frames the first acquired sample.
  always @(posedge strobe_i or negedge strobe_reset_n_i) begin
    if (!strobe_reset_n_i) begin
      rises = 0;
      first_seen_o = 1'b0;
    end else begin
      rises++;
      if (rises == 3) begin
        first_word_o = word_i;
        first_seen_o = 1'b1;
      end
    end
  end

endmodule : strobe_capture_model

/* tb_top.sv */
// Self-checking bench for the converter output timing block.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_strobe_pkg::*;

  logic core_clk = 1'b0;
  logic conv_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic srn = 1'b1;
  conv_word_t sample = '0;
  conv_word_t word;
  conv_word_t first_word;
  conv_word_t first_exp;
  conv_word_t hist [5];
  logic strobe;
  logic running;
  logic first_pulse;
  logic first_seen;
  logic [7:0] rcount;
  logic [7:0] exp_cnt = 8'h00;
  logic arm = 1'b0;
  logic es = 1'b0;
  int nrise = 0;
  int error_cnt = 0;
  int checks_done = 0;

  // ==========================================================================
  // Clocks and instances
  always #20 core_clk = ~core_clk;
  always #32 conv_clk = ~conv_clk;

  adc_strobe_timing u_adc_strobe_timing (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .conversion_clock_i(conv_clk),
    .strobe_reset_n_i(srn), .sample_word_i(sample), .converted_word_o(word),
    .output_valid_strobe_o(strobe), .strobe_running_o(running),
    .first_word_pulse_o(first_pulse), .restart_count_o(rcount)
  );

  strobe_capture_model u_strobe_capture_model (
    .strobe_i(strobe), .strobe_reset_n_i(srn), .word_i(word),
    .capt_word_o(), .first_seen_o(first_seen), .first_word_o(first_word)
  );

  // ==========================================================================
  // Reporting and compares
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic fail(input string msg);
    error_cnt++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : cmp_bit

  task automatic cmp_word(input conv_word_t got, input conv_word_t exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : cmp_word

  task automatic cmp_cnt(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : cmp_cnt

  // ==========================================================================
  // Expected strobe: armed by the first rise after release, toggled on falls.
  always @(posedge conv_clk or negedge srn) begin
    if (!srn) arm = 1'b0;
    else begin
      if (!arm) first_exp = sample;
      arm = 1'b1;
    end
  end

  always @(negedge conv_clk or negedge srn) begin
    if (!srn) es = 1'b0;
    else if (arm) es = ~es;
  end

  always @(conv_clk) begin
    #3;
    cmp_bit(strobe, es, "strobe level");
  end

  // Random samples and the four-period data latency.
  always @(posedge conv_clk) begin
    for (int i = 4; i > 0; i--) hist[i] <= hist[i-1];
    hist[0] <= sample;
    nrise <= nrise + 1;
    #2;
    sample = conv_word_t'($urandom);
    #1;
    if (nrise > 5) cmp_word(word, hist[4], "data latency");
  end

  always @(posedge first_seen) begin
    #1;
    cmp_word(first_word, first_exp, "first word");
  end

  // ==========================================================================
  // Restart with release while the conversion clock is high or low.
  task automatic restart(input logic hi);
    int n;
    @(negedge core_clk);
    srn = 1'b0;
    #1;
    cmp_bit(strobe, 1'b0, "async clear");
    repeat (10 + $urandom % 6) @(negedge core_clk);
    cmp_bit(running, 1'b0, "running low");
    if (hi) @(posedge conv_clk);
    else @(negedge conv_clk);
    #10;
    srn = 1'b1;
    n = 0;
    while (first_pulse !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (first_pulse !== 1'b1) begin
      fail("no first word");
      end_sim();
    end
    cmp_bit(running, 1'b1, "running high");
    exp_cnt = exp_cnt + 8'h01;
    @(posedge core_clk);
    #1;
    cmp_cnt(rcount, exp_cnt, "restart count");
    cmp_bit(first_pulse, 1'b0, "pulse width");
  endtask : restart

  initial begin
    void'($urandom(82948));
    #1;
    srn = 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    cmp_cnt(rcount, 8'h00, "count reset");
    cmp_bit(first_pulse, 1'b0, "pulse reset");
    for (int i = 0; i < 6; i++) begin
      restart(i[0]);
      repeat (20 + $urandom % 30) @(negedge core_clk);
    end
    // Shortest allowed strobe reset pulse.
    @(negedge core_clk);
    srn = 1'b0;
    #1;
    cmp_bit(strobe, 1'b0, "short pulse clear");
    srn = 1'b1;
    repeat (300) @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    cmp_cnt(rcount, 8'h00, "count mid reset");
    @(negedge core_clk);
    cmp_cnt(rcount, 8'h00, "count after reset");
    cmp_bit(first_pulse, 1'b0, "pulse after reset");
    exp_cnt = 8'h00;
    restart(1'b0);
    repeat (100) @(negedge core_clk);
    end_sim();
  end

endmodule : tb_top
